// ===== verification/fnmrf_props.sv
// Checker for the device timer and control outputs against the link
`timescale 1ns/1ps
`default_nettype none
module fnmrf_props
  import fnmrf_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire fnmrf_cfg_t cfg, // Settings
  input wire logic latch_strobe, // Load strobe
  input wire logic pfd_en, // Tick
  input wire logic loop_filter_switch, // Switch
  input wire logic [7:0] cp_setting, // Pump
  input wire logic sync_pulse, // Sync
  input wire logic phase_realign, // Realign
  input wire logic band_sel_en, // Band select
  input wire logic fast_active // Fast lock
);
  // ****
  // Helpers
  // ****
  logic [2:0] ls_q, ls_d;
  logic [23:0] pc_q, pc_d, fc_q, fc_d, span;
  logic [1:0] ns_q, ns_d;
  logic quiet;
  assign span = 24'(cfg.clk_div) * 24'(cfg.fractional_modulus);
  assign quiet = ls_q == 3'h0 && !latch_strobe;
  // Ticks since last sync, ticks in fast lock, syncs since load
  always_comb
  begin
    ls_d = {ls_q[1:0], latch_strobe};
    pc_d = sync_pulse ? 24'(pfd_en) : pc_q + 24'(pfd_en);
    fc_d = fast_active && !latch_strobe ? fc_q + 24'(pfd_en) : 24'h0;
    ns_d = latch_strobe ? 2'h0 : ns_q + 2'(sync_pulse && ns_q != 2'h3);
  end
  // Register the helpers
  always_ff @(posedge sys_clk)
  begin
    ls_q <= rst ? 3'h0 : ls_d;
    pc_q <= rst ? 24'h0 : pc_d;
    fc_q <= rst ? 24'h0 : fc_d;
    ns_q <= rst ? 2'h0 : ns_d;
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence settle_s;
    latch_strobe ##1 !latch_strobe [*2];
  endsequence
  sequence fast_load_s;
    latch_strobe && cfg.timer_mode == 2'h1 ##1 !latch_strobe [*2];
  endsequence
  band_sel_a: assert property (
    settle_s |=> band_sel_en == !$past(cfg.phase_adjust, 3)) else $error("band select");
  fast_start_a: assert property (fast_load_s |=> fast_active)
    else $error("fast start");
  switch_fast_a: assert property (loop_filter_switch == fast_active
    && (!loop_filter_switch || latch_strobe || cfg.timer_mode == 2'h1)) else $error("switch");
  cp_boost_a: assert property (quiet |-> cp_setting ==
    (fast_active ? {cfg.cp_current, 4'h0} : {4'h0, cfg.cp_current})) else $error("pump");
  idle_timer_a: assert property (quiet && cfg.timer_mode[0] == cfg.timer_mode[1]
    |-> !sync_pulse && !fast_active) else $error("idle timer");
  sync_tick_a: assert property (
    sync_pulse |-> $past(pfd_en) && cfg.timer_mode == 2'h2) else $error("sync tick");
  sync_period_a: assert property (sync_pulse && ns_q != 2'h0 |-> pc_q == span)
    else $error("sync period");
  realign_a: assert property (sync_pulse || phase_realign
    |-> sync_pulse && phase_realign == (ns_q == 2'h1)) else $error("realign");
  fast_len_a: assert property ($fell(fast_active) && quiet |-> fc_q == span)
    else $error("fast length");
endmodule
`default_nettype wire

// ===== verification/test_fraction_numerator_n_modulator_resync_fastlock.sv
// Bench joining host and device ends across the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_fraction_numerator_n_modulator_resync_fastlock;
  import fnmrf_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, pfd_en = 1'b0, pfd_on = 1'b0;
  logic inited = 1'b0, req_err, init_done, loop_filter_switch, sync_pulse, phase_realign;
  logic band_sel_en, band_clk_high, abp_3ns, fast_active;
  logic [11:0] int_offset;
  logic [7:0] cp_setting;
  logic [3:0] sd_code;
  fnmrf_cfg_t req_cfg = '0, c;
  int mismatches = 0, check_count = 0, syncs = 0, aligns = 0, n;
  fnmrf_if lnk ();
  fnmrf_host fnmrf_host_i (.sys_clk, .rst, .req_valid, .req_cfg, .req_err, .init_done,
    .lnk(lnk));
  fnmrf_dev fnmrf_dev_i (.sys_clk, .rst, .pfd_en, .lnk(lnk), .sd_code, .int_offset,
    .loop_filter_switch, .cp_setting, .sync_pulse, .phase_realign, .band_sel_en,
    .band_clk_high, .abp_3ns, .fast_active);
  fnmrf_props fnmrf_props_i (.sys_clk, .rst, .cfg(lnk.cfg), .latch_strobe(lnk.latch_strobe),
    .pfd_en, .loop_filter_switch, .cp_setting, .sync_pulse, .phase_realign, .band_sel_en,
    .fast_active);
  // Clock, random comparison ticks and event counts
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    pfd_en <= pfd_on && !pfd_en && $urandom_range(1) == 1;
    syncs <= syncs + int'(sync_pulse);
    aligns <= aligns + int'(phase_realign);
  end
  // Whether the host must refuse a settings word
  function automatic logic refused(fnmrf_cfg_t c);
    return c.fractional_modulus < 12'h002 || (c.dither_en && c.fractional_modulus < 12'h032)
      || (c.timer_mode == 2'h1 && !inited)
      || (c.timer_mode != 2'h0 && c.clk_div == 12'h000)
      || (c.band_clk_high && c.antibacklash_3ns && c.fraction_numerator != 12'h000);
  endfunction
  // Expected phase step
  function automatic logic [11:0] exp_off(fnmrf_cfg_t c);
    return c.phase_word < c.fractional_modulus ? c.phase_word : 12'h000;
  endfunction
  // Plain settings word
  function automatic fnmrf_cfg_t mk(logic [11:0] m, logic [11:0] d, logic [1:0] t, logic di);
    mk = '0;
    mk.fractional_modulus = m;
    mk.clk_div = d;
    mk.timer_mode = t;
    mk.dither_en = di;
    mk.cp_current = 4'h5;
  endfunction
  // Present one settings word, check the answer and the settled outputs
  task automatic load(input fnmrf_cfg_t c);
    logic e, f;
    e = refused(c);
    f = c.timer_mode == 2'h1;
    pfd_on <= 1'b0;
    @(posedge sys_clk);
    req_cfg <= c;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    `CHK("req_err", e, req_err)
    `CHK("strobe", !e, lnk.latch_strobe)
    inited |= !e;
    `CHK("init_done", inited, init_done)
    repeat (4) @(posedge sys_clk);
    #1;
    if (!e)
    begin
      `CHK("offset", exp_off(c), int_offset)
      `CHK("band_sel", !c.phase_adjust, band_sel_en)
      `CHK("band_clk", c.band_clk_high, band_clk_high)
      `CHK("abp", c.antibacklash_3ns, abp_3ns)
      `CHK("fast", f, fast_active)
      `CHK("switch", f, loop_filter_switch)
      `CHK("cp", f ? {c.cp_current, 4'h0} : {4'h0, c.cp_current}, cp_setting)
    end
    pfd_on <= 1'b1;
  endtask
  // Bounded wait for the wide-bandwidth interval to end
  task automatic wait_fast();
    for (n = 0; n < 2000 && fast_active !== 1'b0; n++)
      @(posedge sys_clk);
    `CHK("fast_end", 1'b1, n < 2000)
    if (n == 2000)
      final_report();
  endtask
  // Modulator mean over twice the modulus in steps must equal the fraction
  task automatic check_code(input fnmrf_cfg_t c);
    int s, k, t, d;
    logic w;
    s = 0;
    k = 0;
    w = 1'b0;
    for (t = 0; t < 4000 && k < 2 * int'(c.fractional_modulus); t++)
    begin
      @(posedge sys_clk);
      #1;
      if (w)
      begin
        s += int'($signed(sd_code));
        k++;
      end
      w = pfd_en;
    end
    d = s - 2 * int'(c.fraction_numerator);
    `CHK("code_steps", 2 * int'(c.fractional_modulus), k)
    `CHK("code_mean", 1'b1, d >= -5 && d <= 5)
    if (k != 2 * int'(c.fractional_modulus))
      final_report();
  endtask
  // Counts and verdict
  task automatic final_report();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Corner cases, then random settings
  initial
  begin
    void'($urandom(95378));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    `CHK("init_done", 1'b0, init_done)
    load(mk(12'h006, 12'h001, 2'h1, 1'b0));
    load(mk(12'h031, 12'h001, 2'h0, 1'b1));
    load(mk(12'h001, 12'h001, 2'h0, 1'b0));
    load(mk(12'h032, 12'h000, 2'h2, 1'b1));
    load(mk(12'hFFF, 12'h001, 2'h0, 1'b1));
    load(mk(12'h003, 12'h002, 2'h2, 1'b0));
    for (n = 0; n < 900 && syncs < 3; n++)
      @(posedge sys_clk);
    #1;
    `CHK("syncs", 3, syncs)
    `CHK("realign", 1, aligns)
    if (n == 900)
      final_report();
    load(mk(12'h002, 12'h001, 2'h1, 1'b0));
    wait_fast();
    for (int i = 0; i < 16; i++)
    begin
      c = 58'({$urandom, $urandom});
      c.fractional_modulus = 12'($urandom_range(80, 2));
      c.fraction_numerator = 12'($urandom_range(int'(c.fractional_modulus) - 1, 0));
      c.clk_div = 12'($urandom_range(3, 1));
      c.phase_word = 12'($urandom_range(int'(c.fractional_modulus), 0));
      load(c);
      wait_fast();
      if (!c.dither_en && !refused(c))
        check_code(c);
      repeat (30) @(posedge sys_clk);
    end
    final_report();
  end
endmodule
`default_nettype wire

// ===== verilog/fnmrf_cfg.svh
// Constants for the fractional-N modulator, timer and control bits
`ifndef FNMRF_CFG_SVH
`define FNMRF_CFG_SVH
`define FNMRF_MOD_MIN 12'h002
`define FNMRF_MOD_MAX 12'hFFF
`define FNMRF_MOD_DITHER_MIN 12'h032
`define FNMRF_DIV_MIN 12'h001
`define FNMRF_TMR_OFF 2'h0
`define FNMRF_TMR_FAST 2'h1
`define FNMRF_TMR_RESYNC 2'h2
`define FNMRF_CP_BOOST 5'h10
`define FNMRF_LFSR_W 21
`define FNMRF_LFSR_SEED 21'h000001
`define FNMRF_SYNC_USE 2'h2
`define FNMRF_FAST_DIV 12'h008
`endif

// ===== verilog/fnmrf_dev.sv
// Device end: sigma-delta modulator, shared timer and control bits
`timescale 1ns/1ps
`default_nettype none
`include "fnmrf_cfg.svh"
module fnmrf_dev
  import fnmrf_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic pfd_en, // Comparison-rate enable pulse
  fnmrf_if.dev lnk, // Link from host
  output logic [3:0] sd_code, // Signed modulator code to N divider
  output logic [11:0] int_offset, // Phase step, 360 over modulus each
  output logic loop_filter_switch, // High: switch tied to analog_ground
  output logic [7:0] cp_setting, // Effective charge pump setting
  output logic sync_pulse, // One-cycle sync pulse
  output logic phase_realign, // Phase realignment strobe
  output logic band_sel_en, // VCO band selection allowed on load
  output logic band_clk_high, // High band-select clock mode
  output logic abp_3ns, // Antibacklash pulse 3 ns
  output logic fast_active // Wide-bandwidth interval running
);
  fnmrf_cfg_t cfg_q, cfg_d;
  logic [11:0] a1_q, a2_q, a3_q, a1_d, a2_d, a3_d;
  logic c1_q, c2_q, c3_q, c1_d, c2_d, c3_d;
  logic c2p_q, c3p_q, c3pp_q, c2p_d, c3p_d, c3pp_d;
  logic [`FNMRF_LFSR_W-1:0] lfsr_q, lfsr_d;
  logic [11:0] mcnt_q, mcnt_d, dcnt_q, dcnt_d;
  logic [1:0] nsync_q, nsync_d;
  logic [3:0] code_q, code_d;
  logic [11:0] off_q, off_d;
  logic sw_q, sw_d, sp_q, sp_d, ra_q, ra_d, fast_q, fast_d;
  logic [7:0] cp_q, cp_d;
  logic bs_q, bs_d, bch_q, bch_d, ab_q, ab_d;
  logic [11:0] modv, fraction_numerator_in;
  logic [12:0] s1, s2, s3;
  logic tick_end;
  fnmrf_tmode_t tm;

  // ************************************************************
  // Modulator
  // ************************************************************
  // Three cascaded accumulators with noise-shaped carry combination
  always_comb
  begin
    cfg_d = cfg_q;
    if (lnk.latch_strobe)
      cfg_d = lnk.cfg;
    modv = (cfg_q.fractional_modulus < `FNMRF_MOD_MIN) ? `FNMRF_MOD_MIN
                                                        : cfg_q.fractional_modulus;
    // Dither adds the LFSR lsb so the pattern stretches to 2^21 - 1 steps
    fraction_numerator_in = cfg_q.fraction_numerator;
    if (cfg_q.dither_en && lfsr_q[0] && fraction_numerator_in < modv - 12'h001)
      fraction_numerator_in = fraction_numerator_in + 12'h001;
    s1 = {1'b0, a1_q} + {1'b0, fraction_numerator_in};
    // Later stages take the residue of the stage before in the same step
    s2 = {1'b0, a2_q} + s1[12:0] - (s1 >= {1'b0, modv} ? {1'b0, modv} : 13'h0000);
    s3 = {1'b0, a3_q} + ((s2 >= {1'b0, modv}) ? s2 - {1'b0, modv} : s2);
    a1_d = a1_q;
    a2_d = a2_q;
    a3_d = a3_q;
    c1_d = c1_q;
    c2_d = c2_q;
    c3_d = c3_q;
    c2p_d = c2p_q;
    c3p_d = c3p_q;
    c3pp_d = c3pp_q;
    lfsr_d = lfsr_q;
    code_d = code_q;
    if (lnk.latch_strobe)
    begin
      // Seed from phase word; sequence pattern depends on it
      a1_d = lnk.cfg.phase_word;
      a2_d = 12'h000;
      a3_d = 12'h000;
      {c1_d, c2_d, c3_d, c2p_d, c3p_d, c3pp_d} = 6'h00;
      lfsr_d = `FNMRF_LFSR_SEED;
    end
    else if (pfd_en)
    begin
      // One step per comparison cycle; repeat length set by modulus
      c1_d = (s1 >= {1'b0, modv});
      a1_d = c1_d ? 12'(s1 - {1'b0, modv}) : s1[11:0];
      c2_d = (s2 >= {1'b0, modv});
      a2_d = c2_d ? 12'(s2 - {1'b0, modv}) : s2[11:0];
      c3_d = (s3 >= {1'b0, modv});
      a3_d = c3_d ? 12'(s3 - {1'b0, modv}) : s3[11:0];
      c2p_d = c2_q;
      c3p_d = c3_q;
      c3pp_d = c3p_q;
      // MASH 1-1-1 output: c1 + (c2 - c2') + (c3 - 2c3' + c3'')
      code_d = 4'({3'b000, c1_q} + {3'b000, c2_q} - {3'b000, c2p_q} + {3'b000, c3_q}
               - {2'b00, c3p_q, 1'b0} + {3'b000, c3pp_q});
      lfsr_d = {lfsr_q[`FNMRF_LFSR_W-2:0], lfsr_q[20] ^ lfsr_q[18]};
    end
  end

  // Register modulator state
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_q <= '0;
      a1_q <= 12'h000;
      a2_q <= 12'h000;
      a3_q <= 12'h000;
      {c1_q, c2_q, c3_q, c2p_q, c3p_q, c3pp_q} <= 6'h00;
      lfsr_q <= `FNMRF_LFSR_SEED;
      code_q <= 4'h0;
    end
    else
    begin
      cfg_q <= cfg_d;
      a1_q <= a1_d;
      a2_q <= a2_d;
      a3_q <= a3_d;
      {c1_q, c2_q, c3_q, c2p_q, c3p_q, c3pp_q} <= {c1_d, c2_d, c3_d, c2p_d, c3p_d, c3pp_d};
      lfsr_q <= lfsr_d;
      code_q <= code_d;
    end
  end

  // ************************************************************
  // Shared timer and control bits
  // ************************************************************
  // Counts modulus cycles per divider tick, divider ticks per interval
  always_comb
  begin
    tm = fnmrf_tmode_t'(cfg_q.timer_mode);
    tick_end = pfd_en && mcnt_q >= modv - 12'h001
               && dcnt_q >= ((cfg_q.clk_div < `FNMRF_DIV_MIN) ? `FNMRF_DIV_MIN
                                                                : cfg_q.clk_div) - 12'h001;
    mcnt_d = mcnt_q;
    dcnt_d = dcnt_q;
    nsync_d = nsync_q;
    fast_d = fast_q;
    sp_d = 1'b0;
    ra_d = 1'b0;
    if (lnk.latch_strobe)
    begin
      mcnt_d = 12'h000;
      dcnt_d = 12'h000;
      nsync_d = 2'h0;
      fast_d = (lnk.cfg.timer_mode == `FNMRF_TMR_FAST);
    end
    else if (tm == FNMRF_TM_FAST || tm == FNMRF_TM_RESYNC)
    begin
      if (pfd_en)
      begin
        mcnt_d = (mcnt_q >= modv - 12'h001) ? 12'h000 : mcnt_q + 12'h001;
        if (mcnt_q >= modv - 12'h001)
          dcnt_d = tick_end ? 12'h000 : dcnt_q + 12'h001;
      end
      if (tick_end && tm == FNMRF_TM_FAST)
        fast_d = 1'b0;
      if (tick_end && tm == FNMRF_TM_RESYNC)
      begin
        sp_d = 1'b1;
        if (nsync_q != `FNMRF_SYNC_USE)
          nsync_d = nsync_q + 2'h1;
        ra_d = (nsync_q == `FNMRF_SYNC_USE - 2'h1);
      end
    end
    else
      fast_d = 1'b0;
    sw_d = fast_d;
    cp_d = fast_d ? 8'({4'h0, cfg_q.cp_current} * `FNMRF_CP_BOOST)
                  : {4'h0, cfg_q.cp_current};
    bs_d = !cfg_q.phase_adjust;
    bch_d = cfg_q.band_clk_high;
    ab_d = cfg_q.antibacklash_3ns;
    off_d = (cfg_q.phase_word < modv) ? cfg_q.phase_word : 12'h000;
  end

  // Register timer and control outputs
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mcnt_q <= 12'h000;
      dcnt_q <= 12'h000;
      nsync_q <= 2'h0;
      {fast_q, sw_q, sp_q, ra_q, bs_q, bch_q, ab_q} <= 7'h00;
      cp_q <= 8'h00;
      off_q <= 12'h000;
    end
    else
    begin
      mcnt_q <= mcnt_d;
      dcnt_q <= dcnt_d;
      nsync_q <= nsync_d;
      {fast_q, sw_q, sp_q, ra_q, bs_q, bch_q, ab_q} <= {fast_d, sw_d, sp_d, ra_d, bs_d, bch_d, ab_d};
      cp_q <= cp_d;
      off_q <= off_d;
    end
  end

  assign sd_code = code_q;
  assign int_offset = off_q;
  assign loop_filter_switch = sw_q;
  assign cp_setting = cp_q;
  assign sync_pulse = sp_q;
  assign phase_realign = ra_q;
  assign band_sel_en = bs_q;
  assign band_clk_high = bch_q;
  assign abp_3ns = ab_q;
  assign fast_active = fast_q;
endmodule
`default_nettype wire

// ===== verilog/fnmrf_host.sv
// Host end: checks and latches a settings word onto the link
`timescale 1ns/1ps
`default_nettype none
`include "fnmrf_cfg.svh"
module fnmrf_host
  import fnmrf_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic req_valid, // Load request
  input wire fnmrf_cfg_t req_cfg, // Settings to load
  output logic req_err, // Request refused
  output logic init_done, // Initial load done
  fnmrf_if.host lnk // Link to device
);
  fnmrf_cfg_t cfg_q, cfg_d;
  logic le_q, le_d, err_q, err_d, init_q, init_d;
  logic bad;

  // Check host obligations and build next link state
  always_comb
  begin
    bad = 1'b0;
    if (req_cfg.dither_en && req_cfg.fractional_modulus < `FNMRF_MOD_DITHER_MIN)
      bad = 1'b1;
    if (req_cfg.fractional_modulus < `FNMRF_MOD_MIN)
      bad = 1'b1;
    if (!init_q && req_cfg.timer_mode == `FNMRF_TMR_FAST)
      bad = 1'b1;
    if (req_cfg.timer_mode != `FNMRF_TMR_OFF && req_cfg.clk_div < `FNMRF_DIV_MIN)
      bad = 1'b1;
    if (req_cfg.band_clk_high && req_cfg.fraction_numerator != 12'h000
        && req_cfg.antibacklash_3ns)
      bad = 1'b1;
    cfg_d = cfg_q;
    le_d = 1'b0;
    err_d = 1'b0;
    init_d = init_q;
    if (req_valid)
    begin
      if (bad)
        err_d = 1'b1;
      else
      begin
        cfg_d = req_cfg;
        le_d = 1'b1;
        init_d = 1'b1;
      end
    end
  end

  // Register link state
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_q <= '0;
      le_q <= 1'b0;
      err_q <= 1'b0;
      init_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      le_q <= le_d;
      err_q <= err_d;
      init_q <= init_d;
    end
  end

  assign lnk.cfg = cfg_q;
  assign lnk.latch_strobe = le_q;
  assign req_err = err_q;
  assign init_done = init_q;
endmodule
`default_nettype wire

// ===== verilog/fnmrf_if.sv
// Link between host controller and synthesizer control logic
`timescale 1ns/1ps
`default_nettype none
interface fnmrf_if;
  import fnmrf_pkg::*;
  fnmrf_cfg_t cfg;
  logic latch_strobe;
  modport host (output cfg, output latch_strobe);
  modport dev (input cfg, input latch_strobe);
endinterface
`default_nettype wire

// ===== verilog/fnmrf_pkg.sv
// Types shared by both ends of the synthesizer control link
`default_nettype none
package fnmrf_pkg;
  typedef enum logic [1:0] {
    FNMRF_TM_OFF = 2'b00,
    FNMRF_TM_FAST = 2'b01,
    FNMRF_TM_RESYNC = 2'b10,
    FNMRF_TM_RSVD = 2'b11
  } fnmrf_tmode_t;
  typedef struct packed {
    logic [11:0] fractional_modulus;
    logic [11:0] fraction_numerator;
    logic [11:0] phase_word;
    logic [11:0] clk_div;
    logic [1:0] timer_mode;
    logic dither_en;
    logic phase_adjust;
    logic band_clk_high;
    logic antibacklash_3ns;
    logic [3:0] cp_current;
  } fnmrf_cfg_t;
endpackage
`default_nettype wire
